// ---- hdl/adc_seq_pkg.sv ----
// Register map, field layout and sequencing constants of the conversion sequencer.
package adc_seq_pkg;
  // Printed register offsets are word indices; the byte address is four times the index.
  localparam logic [7:0] CTRL_IDX = 8'h38;
  localparam logic [7:0] RESULT_IDX = 8'h39;
  localparam logic [7:0] CLOCK_IDX = 8'h3A;
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] RESULT_ADDR = {RESULT_IDX, 2'b00};
  localparam logic [9:0] CLOCK_ADDR = {CLOCK_IDX, 2'b00};

  // Control and status register fields.
  localparam int FLAG_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int CH_MSB = 4;
  localparam logic [4:0] CH_POWER_OFF = 5'h1F;
  localparam logic [4:0] CH_RESET = 5'h1F;
  localparam logic [4:0] CH_REF_HIGH = 5'h1D;
  localparam logic [4:0] CH_REF_LOW = 5'h1E;

  // Clock register fields.
  localparam int DIV_MSB = 2;
  localparam int SRC_BIT = 4;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic SRC_RESET = 1'b0;

  // One conversion is sixteen converter clocks: the start clock, seven of sampling, eight of approximation.
  localparam logic [3:0] LAST_PHASE = 4'hF;
  localparam logic [3:0] FIRST_DECIDE_PHASE = 4'h8;
  localparam logic [3:0] START_PHASE = 4'h1;
  localparam logic [7:0] SAR_START = 8'h80;
  localparam logic [3:0] DIV16_LAST = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage : adc_seq_pkg

// ---- hdl/conv_clock_divider.sv ----
// Converter clock prescaler producing a one-cycle tick per converter clock period.
`timescale 1ns/10ps
`default_nettype none
module conv_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic crystal_ref_clock,
  input wire logic converter_clock_source_select,
  input wire logic [2:0] clock_divide_field,
  output logic conv_tick
);
  logic xsync1;
  logic xsync2;
  logic xsync3;
  logic input_edge;
  logic [3:0] count;
  logic [3:0] last_count;

  function automatic logic [3:0] div_last(input logic [2:0] field);
    if (field[2])
      div_last = adc_seq_pkg::DIV16_LAST;
    else
      div_last = 4'(({3'h0, 1'b1} << field[1:0]) - 4'h1);
  endfunction : div_last

  // The crystal clock is sampled as a level; the second and third stages feed the edge detector.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xsync1 <= 1'b0;
      xsync2 <= 1'b0;
      xsync3 <= 1'b0;
    end
    else
    begin
      xsync1 <= crystal_ref_clock;
      xsync2 <= xsync1;
      xsync3 <= xsync2;
    end
  end

  assign input_edge = converter_clock_source_select ? 1'b1 : (xsync2 & ~xsync3);
  assign last_count = div_last(clock_divide_field);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 4'h0;
      conv_tick <= 1'b0;
    end
    else
    begin
      conv_tick <= 1'b0;
      if (input_edge)
      begin
        if (count >= last_count)
        begin
          count <= 4'h0;
          conv_tick <= 1'b1;
        end
        else
          count <= count + 4'h1;
      end
    end
  end
endmodule : conv_clock_divider
`default_nettype wire

// ---- hdl/adc_conversion_sequencer.sv ----
// Register file, channel multiplexer control and successive-approximation sequencer.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer #(
  parameter int PIN_COUNT = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_ref_clock,
  input wire logic comparator_high,
  output logic [7:0] sar_trial,
  output logic sample_enable,
  output logic [4:0] selected_analog_input,
  output logic converter_power_down,
  output logic done_irq,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic [PIN_COUNT-1:0] port_data_latch,
  input wire logic [PIN_COUNT-1:0] port_direction,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe,
  output logic [PIN_COUNT-1:0] analog_pin_select,
  output logic [PIN_COUNT-1:0] port_read_value
);
  logic conversion_done_flag, done_irq_enable, continuous_convert_select;
  logic converter_clock_source_select;
  logic [4:0] channel_select_field;
  logic [2:0] clock_divide_field;
  logic [7:0] result, next_sar;
  logic [3:0] phase;
  logic start_pending, conv_tick, setup_phase, access_done, ctrl_write, result_read;
  logic mapped, powered_off, start_evt, complete_evt, decide;
  adc_seq_pkg::conv_state_t state;

  conv_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .crystal_ref_clock(crystal_ref_clock),
    .converter_clock_source_select(converter_clock_source_select),
    .clock_divide_field(clock_divide_field),
    .conv_tick(conv_tick)
  );

  // Resolves one trial bit and proposes the next lower one.
  function automatic logic [7:0] sar_step(input logic [7:0] code, input logic [2:0] bit_idx,
                                          input logic keep);
    logic [7:0] value;
    value = code;
    value[bit_idx] = keep;
    if (bit_idx != 3'h0)
      value[bit_idx - 3'h1] = 1'b1;
    sar_step = value;
  endfunction : sar_step

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable;
  assign mapped = (paddr == adc_seq_pkg::CTRL_ADDR) | (paddr == adc_seq_pkg::RESULT_ADDR) |
                  (paddr == adc_seq_pkg::CLOCK_ADDR);
  assign ctrl_write = access_done & pwrite & (paddr == adc_seq_pkg::CTRL_ADDR);
  assign result_read = access_done & ~pwrite & (paddr == adc_seq_pkg::RESULT_ADDR);
  // Zero-wait slave; unmapped addresses complete with an error and no effect.
  assign pready = 1'b1;
  assign pslverr = access_done & ~mapped;

  assign powered_off = (channel_select_field == adc_seq_pkg::CH_POWER_OFF);
  assign converter_power_down = powered_off;
  assign selected_analog_input = channel_select_field;

  assign start_evt = conv_tick & start_pending & ~powered_off & ~stop_mode;
  assign decide = (state == adc_seq_pkg::ST_CONVERT) & conv_tick & ~start_evt & ~stop_mode &
                  (phase >= adc_seq_pkg::FIRST_DECIDE_PHASE);
  assign complete_evt = decide & (phase == adc_seq_pkg::LAST_PHASE);
  assign next_sar = sar_step(sar_trial, 3'(adc_seq_pkg::LAST_PHASE - phase), comparator_high);
  assign sample_enable = (state == adc_seq_pkg::ST_CONVERT) &
                         (phase < adc_seq_pkg::FIRST_DECIDE_PHASE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_irq_enable <= 1'b0;
      continuous_convert_select <= 1'b0;
      channel_select_field <= adc_seq_pkg::CH_RESET;
      clock_divide_field <= adc_seq_pkg::DIV_RESET;
      converter_clock_source_select <= adc_seq_pkg::SRC_RESET;
    end
    else
    begin
      if (ctrl_write)
      begin
        done_irq_enable <= pwdata[adc_seq_pkg::IEN_BIT];
        continuous_convert_select <= pwdata[adc_seq_pkg::CONT_BIT];
        channel_select_field <= pwdata[adc_seq_pkg::CH_MSB:0];
      end
      if (access_done & pwrite & (paddr == adc_seq_pkg::CLOCK_ADDR))
      begin
        clock_divide_field <= pwdata[adc_seq_pkg::DIV_MSB:0];
        converter_clock_source_select <= pwdata[adc_seq_pkg::SRC_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversion_done_flag <= 1'b0;
    else if (complete_evt)
      conversion_done_flag <= 1'b1;
    else if (ctrl_write | result_read)
      conversion_done_flag <= 1'b0;
  end

  assign done_irq = conversion_done_flag & done_irq_enable;

  // start request crossing
  // A control register write is held as a pending start until the next converter tick consumes it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_pending <= 1'b0;
    else if (ctrl_write)
      start_pending <= 1'b1;
    else if (stop_mode & (state == adc_seq_pkg::ST_CONVERT))
      start_pending <= 1'b1;
    else if (conv_tick & ~stop_mode)
      start_pending <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= adc_seq_pkg::ST_IDLE;
      phase <= 4'h0;
      sar_trial <= 8'h00;
    end
    else if (stop_mode)
    begin
      state <= adc_seq_pkg::ST_IDLE;
      phase <= 4'h0;
    end
    else if (conv_tick)
    begin
      if (start_evt)
      begin
        state <= adc_seq_pkg::ST_CONVERT;
        phase <= adc_seq_pkg::START_PHASE;
        sar_trial <= adc_seq_pkg::SAR_START;
      end
      else if (start_pending)
        state <= adc_seq_pkg::ST_IDLE;
      else
      begin
        unique case (state)
          adc_seq_pkg::ST_IDLE:
            phase <= 4'h0;
          adc_seq_pkg::ST_CONVERT:
          begin
            if (decide)
              sar_trial <= next_sar;
            if (complete_evt)
            begin
              if (continuous_convert_select & ~powered_off)
              begin
                phase <= adc_seq_pkg::START_PHASE;
                sar_trial <= adc_seq_pkg::SAR_START;
              end
              else
                state <= adc_seq_pkg::ST_IDLE;
            end
            else
              phase <= phase + 4'h1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= 8'h00;
    else if (complete_evt)
      result <= next_sar;
  end

  // Read data is captured in the setup phase so it is a flop output during the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_phase & ~pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == adc_seq_pkg::CTRL_ADDR)
        prdata[7:0] <= {conversion_done_flag & ~done_irq_enable, done_irq_enable,
                        continuous_convert_select, channel_select_field};
      else if (paddr == adc_seq_pkg::RESULT_ADDR)
        prdata[7:0] <= result;
      else if (paddr == adc_seq_pkg::CLOCK_ADDR)
        prdata[7:0] <= {3'h0, converter_clock_source_select, 1'b0, clock_divide_field};
    end
  end

  always_comb
  begin
    analog_pin_select = '0;
    for (int i = 0; i < PIN_COUNT; i++)
      if (channel_select_field == 5'(i))
        analog_pin_select[i] = 1'b1;
  end

  assign pin_oe = port_direction & ~analog_pin_select;
  assign pin_out = port_data_latch & pin_oe;

  always_comb
  begin
    port_read_value = '0;
    for (int i = 0; i < PIN_COUNT; i++)
      if (port_direction[i])
        port_read_value[i] = port_data_latch[i];
      else if (!analog_pin_select[i])
        port_read_value[i] = pin_in[i];
  end

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_complete;
    complete_evt;
  endsequence
  sequence s_clear;
    ctrl_write | result_read;
  endsequence
  property p_flag_set;
    s_complete |=> conversion_done_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");
  property p_flag_clear;
    (s_clear and !complete_evt) |=> !conversion_done_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("done flag not cleared");
  property p_irq_hold;
    (done_irq && !ctrl_write && !result_read) |=> done_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
  property p_wake;
    (wait_mode && complete_evt && done_irq_enable) |=> done_irq;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake request in wait");
  property p_flag_hidden;
    (setup_phase && !pwrite && paddr == adc_seq_pkg::CTRL_ADDR && done_irq_enable)
      |=> !prdata[7];
  endproperty
  a_flag_hidden: assert property (p_flag_hidden) else $error("flag visible with irq");
  property p_start;
    start_evt |=> state == adc_seq_pkg::ST_CONVERT && phase == adc_seq_pkg::START_PHASE;
  endproperty
  a_start: assert property (p_start) else $error("conversion did not start");
  property p_result;
    s_complete |=> result == $past(next_sar);
  endproperty
  a_result: assert property (p_result) else $error("result not stored");
  property p_continue;
    (s_complete and (continuous_convert_select && !powered_off))
      |=> state == adc_seq_pkg::ST_CONVERT && phase == adc_seq_pkg::START_PHASE;
  endproperty
  a_continue: assert property (p_continue) else $error("continuous mode stopped");
  property p_stop;
    stop_mode |=> state == adc_seq_pkg::ST_IDLE && !complete_evt;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion ran in stop");
  property p_pin_override;
    (pin_oe & analog_pin_select) == '0;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("selected pin driven");
  property p_pin_read;
    (port_read_value & analog_pin_select) ==
      (port_data_latch & port_direction & analog_pin_select);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("selected pin read wrong");
endmodule : adc_conversion_sequencer
`default_nettype wire

// ---- sim/analog_core_model.sv ----
// Behavioural analog core: channel mux, sample-and-hold and comparator.
`timescale 1ns/10ps
`default_nettype none
module analog_core_model (
  input wire logic pclk,
  input wire logic [7:0] level [12],
  input wire logic [7:0] sar_trial,
  input wire logic sample_enable,
  input wire logic [4:0] selected_analog_input,
  input wire logic converter_power_down,
  output logic comparator_high
);
  logic [7:0] vin;
  logic [7:0] held;
  logic noise = 1'b0;
  always_comb
  begin
    if (selected_analog_input < 5'h0C)
      vin = level[selected_analog_input];
    else if (selected_analog_input == adc_seq_pkg::CH_REF_HIGH)
      vin = 8'hFF;
    else if (selected_analog_input == adc_seq_pkg::CH_REF_LOW)
      vin = 8'h00;
    else
      vin = {8{noise}};
  end
  always_ff @(posedge pclk)
  begin
    noise <= ~noise;
    if (sample_enable)
      held <= vin;
  end
  // comparator per trial
  // A powered-down core answers with noise, so a result taken then cannot look right.
  assign comparator_high = converter_power_down ? noise : (held >= sar_trial);
endmodule : analog_core_model
`default_nettype wire

// ---- sim/adc_conversion_sequencer_bench.sv ----
// Self-checking bench for the conversion sequencer.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_bench;
  localparam logic [9:0] ctrl_a = adc_seq_pkg::CTRL_ADDR;
  localparam logic [9:0] res_a = adc_seq_pkg::RESULT_ADDR;
  localparam logic [9:0] clk_a = adc_seq_pkg::CLOCK_ADDR;
  localparam logic [33:0] dc = 34'h200000000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, crystal_ref_clock;
  logic comparator_high, sample_enable, converter_power_down, done_irq, wait_mode, stop_mode;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] sar_trial, nv;
  logic [4:0] selected_analog_input;
  logic [11:0] latch, dir, pin_in, pin_out, pin_oe, apsel, prv, sel;
  logic [7:0] level [12];
  logic [33:0] exp_q [$];
  logic [33:0] e;
  int n_fail, comparisons, seed, cyc, t0, k;

  adc_conversion_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_ref_clock(crystal_ref_clock),
    .comparator_high(comparator_high), .sar_trial(sar_trial), .sample_enable(sample_enable),
    .selected_analog_input(selected_analog_input), .converter_power_down(converter_power_down),
    .done_irq(done_irq), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .port_data_latch(latch), .port_direction(dir), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .analog_pin_select(apsel), .port_read_value(prv));
  analog_core_model core_u (.pclk(pclk), .level(level), .sar_trial(sar_trial),
    .sample_enable(sample_enable), .selected_analog_input(selected_analog_input),
    .converter_power_down(converter_power_down), .comparator_high(comparator_high));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // The crystal source is deliberately unrelated in phase to the bus clock.
  initial
  begin
    crystal_ref_clock = 1'b0;
    forever #7 crystal_ref_clock = ~crystal_ref_clock;
  end
  always @(posedge pclk)
    cyc <= cyc + 1;

  task finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task chk(input logic [32:0] g, input logic [32:0] x);
    comparisons++;
    if (g !== x)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  function automatic logic [33:0] ex(input logic [7:0] v);
    return {26'h0, v};
  endfunction : ex
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr
  task rd(input logic [9:0] a, input logic [33:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // Reads of the control register until the done flag shows, bounded in cycles.
  task wait_flag(input int lim);
    t0 = cyc;
    q = 32'h0;
    while (q[7] !== 1'b1 && cyc - t0 < lim) rd(ctrl_a, dc);
    if (q[7] !== 1'b1)
      chk(33'h0, 33'h1);
  endtask : wait_flag
  task conv(input logic [4:0] ch, input logic [7:0] v);
    wr(ctrl_a, {3'b000, ch});
    wait_flag(200);
    rd(ctrl_a, ex({3'b100, ch}));
    rd(res_a, ex(v));
    rd(ctrl_a, ex({3'b000, ch}));
  endtask : conv

  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_q.pop_front();
      if (!e[33])
        chk({pslverr, prdata}, e[32:0]);
    end

  initial
  begin
    #200000;
    n_fail++;
    finish_test();
  end

  initial
  begin
    seed = 31;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    latch = 12'h000;
    dir = 12'h000;
    pin_in = 12'h000;
    for (k = 0; k < 12; k++) level[k] = 8'($random(seed));
    level[0] = 8'hFF;
    level[11] = 8'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ctrl_a, ex(8'h1F));
    rd(clk_a, ex(8'h00));
    chk(33'(converter_power_down), 33'h1);
    rd(10'h3FC, 34'h100000000);
    wr(clk_a, 8'h10);
    wr(ctrl_a, 8'h1F);
    repeat (40) @(posedge pclk);
    rd(ctrl_a, ex(8'h1F));
    for (k = 0; k < 14; k++) conv(5'(k < 12 ? k : k + 17), k < 12 ? level[k] : {8{k == 12}});
    wait_mode <= 1'b1;
    wr(ctrl_a, 8'h43);
    t0 = cyc;
    while (done_irq !== 1'b1 && cyc - t0 < 100) @(posedge pclk);
    chk(33'((cyc - t0) inside {[16:19]}), 33'h1);
    rd(ctrl_a, ex(8'h43));
    repeat (20) @(posedge pclk);
    chk(33'(done_irq), 33'h1);
    rd(res_a, ex(level[3]));
    @(posedge pclk);
    chk(33'(done_irq), 33'h0);
    wait_mode <= 1'b0;
    wr(res_a, 8'h55);
    rd(res_a, ex(level[3]));
    wr(ctrl_a, 8'h25);
    wait_flag(200);
    rd(res_a, ex(level[5]));
    nv = level[5] ^ 8'hA5;
    level[5] <= nv;
    wait_flag(200);
    rd(res_a, dc);
    wait_flag(200);
    rd(res_a, ex(nv));
    wr(ctrl_a, 8'h05);
    wait_flag(200);
    rd(res_a, ex(nv));
    repeat (60) @(posedge pclk);
    rd(ctrl_a, ex(8'h05));
    wr(ctrl_a, 8'h07);
    repeat (5) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(ctrl_a, ex(8'h07));
    stop_mode <= 1'b0;
    repeat (17) @(posedge pclk);
    wait_flag(200);
    rd(res_a, ex(level[7]));
    for (k = 0; k < 13; k++)
    begin
      latch <= 12'($random(seed));
      dir <= 12'($random(seed));
      pin_in <= 12'($random(seed));
      wr(ctrl_a, k < 12 ? 8'(k) : 8'h1F);
      @(posedge pclk);
      sel = k < 12 ? 12'h001 << k : 12'h000;
      chk(33'(apsel), 33'(sel));
      chk(33'(pin_oe), 33'(dir & ~sel));
      chk(33'(pin_out), 33'(latch & dir & ~sel));
      chk(33'(prv), 33'((dir & latch) | (~dir & pin_in & ~sel)));
    end
    wr(ctrl_a, 8'h5F);
    wait_mode <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(33'({done_irq, converter_power_down}), 33'h1);
    wait_mode <= 1'b0;
    // Divide field 5 has its top bit set, so the low bits must not matter.
    wr(clk_a, 8'h05);
    wr(ctrl_a, 8'h02);
    wait_flag(3000);
    chk(33'((cyc - t0) inside {[400:1300]}), 33'h1);
    rd(res_a, ex(level[2]));
    // Bus-clock source with divide by 2, 4 and 8: the conversion time must scale with it.
    for (k = 1; k < 4; k++)
    begin
      wr(clk_a, 8'h10 | 8'(k));
      wr(ctrl_a, 8'h40 | 8'(k));
      t0 = cyc;
      while (done_irq !== 1'b1 && cyc - t0 < 400) @(posedge pclk);
      chk(33'((cyc - t0) inside {[(15 << k) + 1:(17 << k) + 2]}), 33'h1);
      rd(res_a, ex(level[k]));
    end
    finish_test();
  end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
